// *** hw/timer_channel.sv ***
// One 16-bit timer channel with five counting modes behind an Avalon-MM slave
// Functional notes
// - Count clock is the selected operating clock, or timer input valid edges.
// - Operating clock ranges system clock to /2^15, one-cycle pulses; undivided stays high.
// - Counter moves one system clock after each count clock rising edge.
// - Input edges sampled on operating clock; count pulse latency one to two cycles.
// - Noise filter adds two more operating-clock cycles to edge detection.
// - Writing the start bit sets the enable status.
// - Interval and capture modes: counter holds until a count clock; first pulse after enable is start trigger.
// - Interval and capture modes raise interrupt on start trigger when selected.
// - Interval mode: first count clock loads data register, later ones decrement.
// - Interval mode: count clock after zero interrupts, reloads, keeps counting.
// - Divided operating pulse, start trigger, interrupt each last exactly one system clock.
// - Event counter holds its value while stopped.
// - Event counter loads the data register at once when started.
// - Event counter decrements on each detected valid input edge.
// - Capture mode: first count clock clears counter, then each operating clock pulse increments.
// - Capture mode: valid edge captures, interrupts, restarts from zero.
// - Single and capture-single modes: start arms; input rising edge triggers.
// - Single mode: trigger loads data register, count clocks decrement.
// - Single mode: at zero interrupt, counter to all ones, back to armed.
// - Capture-single mode: trigger clears counter, then counts up.
// - Capture-single mode: falling edge captures counter and interrupts.
// - Counter and data register are sixteen bits wide.
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_defines.svh"

module timer_channel
	import timer_channel_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [1:0]  response,
	// Timer input pin
	input  wire logic        timerInputPin,
	// Events
	output logic             channelInterrupt,
	output logic             startTrigger
);

	mode_reg_s                modeReg_q;
	presc_reg_s               prescReg_q;
	logic [`TC_WIDTH-1:0]     dataReg_q;
	logic [`TC_WIDTH-1:0]     counter_q;
	logic                     enableStatus_q;
	chan_state_e              state_q;
	logic                     accDone_q;
	logic [14:0]              prescCnt_q;
	logic                     pinSync1_q;
	logic                     pinSync2_q;
	logic                     pinSamp_q;
	logic [`TC_FILTER_DELAY-1:0] filtShift_q;
	logic                     pinPrev_q;
	logic                     countClk_q;
	logic                     risePulse_q;
	logic                     fallPulse_q;
	logic                     irq_q;
	logic                     trig_q;
	logic [15:0]              divTick;
	logic                     opClock;
	logic                     pinFiltered;
	logic                     doWrite;
	logic                     startWrite;
	logic                     stopWrite;
	logic                     dataWrite;
	logic                     countReq;
	logic                     armedMode;
	logic [31:0]              readMux;

	// Prescaler tap select, shared by all four selections
	function automatic logic tapFor(input logic [3:0] sel, input logic [15:0] ticks);
		tapFor = ticks[sel];
	endfunction

	// Bus: one wait cycle on every access, response at the next edge
	assign waitrequest = (read | write) & ~accDone_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			accDone_q <= 1'b0;
		end else begin
			accDone_q <= (read | write) & ~accDone_q;
		end
	end

	assign doWrite    = write & ~waitrequest & byteenable[0];
	assign startWrite = doWrite && address == `TC_ADDR_CTRL && writedata[`TC_CTRL_START];
	assign stopWrite  = doWrite && address == `TC_ADDR_CTRL && writedata[`TC_CTRL_STOP];
	assign dataWrite  = write & ~waitrequest && address == `TC_ADDR_DATA;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			modeReg_q  <= '{filterOn: 1'b0, opClockSel: 2'h0, countSourceSelect: 1'b0,
				mode: MODE_INTERVAL, startIrqSelect: 1'b0};
			prescReg_q <= '0;
		end else if (doWrite) begin
			if (address == `TC_ADDR_MODE)
				modeReg_q <= mode_reg_s'(writedata[7:0]);
			if (address == `TC_ADDR_PRESC)
				prescReg_q <= presc_reg_s'(writedata[15:0]);
		end
	end

	always_comb begin
		readMux  = 32'h0000_0000;
		response = 2'h0;
		case (address)
			`TC_ADDR_MODE:   readMux = {24'h00_0000, modeReg_q};
			`TC_ADDR_PRESC:  readMux = {16'h0000, prescReg_q};
			`TC_ADDR_CTRL:   readMux = 32'h0000_0000;
			`TC_ADDR_DATA:   readMux = {16'h0000, dataReg_q};
			`TC_ADDR_COUNT:  readMux = {16'h0000, counter_q};
			`TC_ADDR_STATUS: readMux = {29'h0, state_q, enableStatus_q};
			default:         response = 2'h2;
		endcase
	end

	// Read data taken in the wait cycle, so it stands when waitrequest drops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= 32'h0000_0000;
		end else begin
			readdata <= readMux;
		end
	end

	// Prescaler: tick k pulses once every 2^k system clocks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prescCnt_q <= 15'h0000;
		end else begin
			prescCnt_q <= prescCnt_q + 15'h0001;
		end
	end

	assign divTick[0] = 1'b1;
	genvar gi;
	generate
		for (gi = 1; gi < 16; gi++) begin : g_tick
			assign divTick[gi] = &prescCnt_q[gi-1:0];
		end
	endgenerate

	always_comb begin
		case (modeReg_q.opClockSel)
			2'h0:    opClock = tapFor(prescReg_q.sel0, divTick);
			2'h1:    opClock = tapFor(prescReg_q.sel1, divTick);
			2'h2:    opClock = tapFor(prescReg_q.sel2, divTick);
			default: opClock = tapFor(prescReg_q.sel3, divTick);
		endcase
	end

	// Pin synchroniser then operating-clock sampling
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
		end else begin
			pinSync1_q <= timerInputPin;
			pinSync2_q <= pinSync1_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSamp_q   <= 1'b0;
			filtShift_q <= '0;
			pinPrev_q   <= 1'b0;
		end else if (opClock) begin
			pinSamp_q   <= pinSync2_q;
			filtShift_q <= {filtShift_q[`TC_FILTER_DELAY-2:0], pinSamp_q};
			pinPrev_q   <= pinFiltered;
		end
	end

	// Filter passes a level only after it stood stable through the chain
	assign pinFiltered = modeReg_q.filterOn ?
		((&filtShift_q) ? 1'b1 : ((|filtShift_q) ? pinPrev_q : 1'b0)) : pinSamp_q;

	// Edge pulses on the operating clock, one system clock wide
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			risePulse_q <= 1'b0;
			fallPulse_q <= 1'b0;
			countClk_q  <= 1'b0;
		end else begin
			risePulse_q <= opClock & pinFiltered & ~pinPrev_q;
			fallPulse_q <= opClock & ~pinFiltered & pinPrev_q;
			countClk_q  <= modeReg_q.countSourceSelect ?
				(opClock & pinFiltered & ~pinPrev_q) : opClock;
		end
	end

	assign armedMode = modeReg_q.mode == MODE_SINGLE || modeReg_q.mode == MODE_CAP_SINGLE;
	assign countReq  = countClk_q;

	// Enable status and sequence state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enableStatus_q <= 1'b0;
			state_q        <= ST_IDLE;
		end else if (stopWrite) begin
			enableStatus_q <= 1'b0;
			state_q        <= ST_IDLE;
		end else if (startWrite) begin
			enableStatus_q <= 1'b1;
			if (armedMode)
				state_q <= ST_ARMED;
			else if (modeReg_q.mode == MODE_EVENT)
				state_q <= ST_RUN;
			else
				state_q <= ST_FIRST;
		end else begin
			case (state_q)
				ST_ARMED: if (risePulse_q) state_q <= ST_RUN;
				ST_FIRST: if (countReq) state_q <= ST_RUN;
				ST_RUN: begin
					if (modeReg_q.mode == MODE_SINGLE && countReq && counter_q == `TC_ZERO)
						state_q <= ST_ARMED;
					if (modeReg_q.mode == MODE_CAP_SINGLE && fallPulse_q)
						state_q <= ST_ARMED;
				end
				ST_IDLE:  state_q <= ST_IDLE;
				default:  state_q <= ST_IDLE;
			endcase
		end
	end

	// Counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			counter_q <= `TC_ZERO;
		end else if (startWrite && modeReg_q.mode == MODE_EVENT) begin
			counter_q <= dataReg_q;
		end else begin
			case (state_q)
				ST_ARMED: if (risePulse_q)
					counter_q <= (modeReg_q.mode == MODE_SINGLE) ? dataReg_q : `TC_ZERO;
				ST_FIRST: if (countReq)
					counter_q <= (modeReg_q.mode == MODE_CAPTURE) ? `TC_ZERO : dataReg_q;
				ST_RUN: begin
					case (modeReg_q.mode)
						MODE_INTERVAL: if (countReq)
							counter_q <= (counter_q == `TC_ZERO) ? dataReg_q
								: counter_q - 16'h0001;
						MODE_EVENT: if (countReq)
							counter_q <= counter_q - 16'h0001;
						MODE_CAPTURE: begin
							if (risePulse_q)
								counter_q <= `TC_ZERO;
							else if (opClock)
								counter_q <= counter_q + 16'h0001;
						end
						MODE_SINGLE: if (countReq)
							counter_q <= (counter_q == `TC_ZERO) ? `TC_ALL_ONES
								: counter_q - 16'h0001;
						MODE_CAP_SINGLE: if (opClock && !fallPulse_q)
							counter_q <= counter_q + 16'h0001;
						default: counter_q <= counter_q;
					endcase
				end
				default: counter_q <= counter_q;
			endcase
		end
	end

	// Data register: software writes, captures override
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dataReg_q <= `TC_ZERO;
		end else if (state_q == ST_RUN && modeReg_q.mode == MODE_CAPTURE && risePulse_q) begin
			dataReg_q <= counter_q;
		end else if (state_q == ST_RUN && modeReg_q.mode == MODE_CAP_SINGLE && fallPulse_q) begin
			dataReg_q <= counter_q;
		end else if (dataWrite) begin
			dataReg_q <= writedata[15:0];
		end
	end

	// Interrupt and start trigger, one system clock each
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q  <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			trig_q <= (state_q == ST_FIRST && countReq && !stopWrite)
				|| (state_q == ST_ARMED && risePulse_q && !stopWrite);
			irq_q  <= !stopWrite && (
				(state_q == ST_FIRST && countReq && modeReg_q.startIrqSelect
					&& (modeReg_q.mode == MODE_INTERVAL || modeReg_q.mode == MODE_CAPTURE))
				|| (state_q == ST_RUN && countReq && counter_q == `TC_ZERO
					&& (modeReg_q.mode == MODE_INTERVAL || modeReg_q.mode == MODE_SINGLE))
				|| (state_q == ST_RUN && risePulse_q && modeReg_q.mode == MODE_CAPTURE)
				|| (state_q == ST_RUN && fallPulse_q && modeReg_q.mode == MODE_CAP_SINGLE));
		end
	end

	assign channelInterrupt = irq_q;
	assign startTrigger     = trig_q;

	// Pulse widths, start and stop sequencing, per-mode counter updates
	a_irq_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		irq_q |=> !irq_q) else $error("interrupt longer than one cycle");
	a_trig_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		trig_q |=> !trig_q) else $error("start trigger longer than one cycle");
	a_start_enables: assert property (@(posedge clk) disable iff (!reset_n)
		startWrite && !stopWrite |=> enableStatus_q) else $error("start did not enable");
	a_stop_clears: assert property (@(posedge clk) disable iff (!reset_n)
		stopWrite |=> !enableStatus_q && state_q == ST_IDLE) else $error("stop did not disable");
	a_stop_freezes: assert property (@(posedge clk) disable iff (!reset_n)
		stopWrite ##1 !startWrite [*2] |-> $stable(counter_q)) else $error("counter moved after stop");
	a_event_load: assert property (@(posedge clk) disable iff (!reset_n)
		startWrite && !stopWrite && modeReg_q.mode == MODE_EVENT |=> counter_q == $past(dataReg_q))
		else $error("event load missing");
	a_first_load: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_FIRST && modeReg_q.mode == MODE_INTERVAL && countReq && !startWrite
		&& !stopWrite |=> counter_q == $past(dataReg_q) && state_q == ST_RUN)
		else $error("interval first load wrong");
	a_start_irq: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_FIRST && countReq && modeReg_q.startIrqSelect && !stopWrite
		&& (modeReg_q.mode == MODE_INTERVAL || modeReg_q.mode == MODE_CAPTURE)
		|=> irq_q && trig_q) else $error("start interrupt missing");
	a_interval_reload: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_RUN && modeReg_q.mode == MODE_INTERVAL && countReq && counter_q == 16'h0000
		&& !startWrite && !stopWrite && !dataWrite |=> irq_q && counter_q == $past(dataReg_q))
		else $error("interval reload wrong");
	a_single_stop: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_RUN && modeReg_q.mode == MODE_SINGLE && countReq && counter_q == 16'h0000
		&& !startWrite && !stopWrite |=> counter_q == 16'hFFFF && state_q == ST_ARMED)
		else $error("single count end wrong");
	a_capture_take: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_RUN && modeReg_q.mode == MODE_CAPTURE && risePulse_q && !startWrite && !stopWrite
		|=> dataReg_q == $past(counter_q) && counter_q == 16'h0000 && irq_q)
		else $error("capture wrong");
	a_capsingle_take: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_RUN && modeReg_q.mode == MODE_CAP_SINGLE && fallPulse_q && !startWrite
		&& !stopWrite |=> dataReg_q == $past(counter_q) && irq_q && state_q == ST_ARMED)
		else $error("high width capture wrong");
	a_count_delay: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_RUN && modeReg_q.mode == MODE_EVENT && !countClk_q && !startWrite
		|=> $stable(counter_q)) else $error("event counter moved without edge");
	a_op_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		prescReg_q.sel0 == 4'h1 && modeReg_q.opClockSel == 2'h0 && $stable(prescReg_q) && opClock
		|=> !opClock) else $error("divided clock wider than one cycle");

endmodule

`default_nettype wire

// *** include/timer_channel_defines.svh ***
// Timer channel constants: register map and fields, prescaler limits, counter values
`ifndef TIMER_CHANNEL_DEFINES_SVH
`define TIMER_CHANNEL_DEFINES_SVH

`define TC_WIDTH        16
`define TC_ZERO         16'h0000
`define TC_ALL_ONES     16'hFFFF
`define TC_PRESC_MAX    4'hF
`define TC_PRESC_BITS   15
`define TC_FILTER_DELAY 2

// Register map (word index on the bus)
`define TC_ADDR_MODE    4'h0
`define TC_ADDR_PRESC   4'h1
`define TC_ADDR_CTRL    4'h2
`define TC_ADDR_DATA    4'h3
`define TC_ADDR_COUNT   4'h4
`define TC_ADDR_STATUS  4'h5

// Mode register fields
`define TC_MODE_START_IRQ 0
`define TC_MODE_LSB       1
`define TC_MODE_SRC       4
`define TC_MODE_CKS_LO    5
`define TC_MODE_CKS_HI    6
`define TC_MODE_FILTER    7

// Control register fields (write one)
`define TC_CTRL_START 0
`define TC_CTRL_STOP  1

`endif

// *** include/timer_channel_pkg.sv ***
// Timer channel types
`default_nettype none

package timer_channel_pkg;

	typedef enum logic [2:0] {
		MODE_INTERVAL   = 3'h0,
		MODE_CAPTURE    = 3'h2,
		MODE_EVENT      = 3'h3,
		MODE_SINGLE     = 3'h4,
		MODE_CAP_SINGLE = 3'h6
	} chan_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_FIRST = 2'b11,
		ST_RUN   = 2'b10
	} chan_state_e;

	typedef struct packed {
		logic       filterOn;
		logic [1:0] opClockSel;
		logic       countSourceSelect;
		chan_mode_e mode;
		logic       startIrqSelect;
	} mode_reg_s;

	typedef struct packed {
		logic [3:0] sel3;
		logic [3:0] sel2;
		logic [3:0] sel1;
		logic [3:0] sel0;
	} presc_reg_s;

endpackage

`default_nettype wire

// *** dv/pin_source.sv ***
// Signal source model driving the timer input pin
`timescale 1ns/1ps
`default_nettype none

module pin_source (
	// Clock
	input  wire logic       clk,
	// Waveform control
	input  wire logic       run,
	input  wire logic [7:0] highLen,
	input  wire logic [7:0] lowLen,
	// Pin
	output logic            timerInputPin
);
	logic [7:0] left;

	// Square wave while running, resting low otherwise
	initial begin
		timerInputPin = 1'b0;
		left = 8'h00;
		forever begin
			@(posedge clk);
			if (!run) begin
				timerInputPin <= 1'b0;
				left = 8'h00;
			end else if (left == 8'h00) begin
				timerInputPin <= ~timerInputPin;
				left = (timerInputPin ? lowLen : highLen) - 8'h01;
			end else begin
				left = left - 8'h01;
			end
		end
	end
endmodule

`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_defines.svh"

module tb
	import timer_channel_pkg::*;
;
	logic        clk, reset_n, read, write, run;
	logic [3:0]  address, byteenable;
	logic [31:0] writedata, readdata, rdata;
	logic [1:0]  response, resp;
	logic        waitrequest, channelInterrupt, startTrigger, pin;
	logic [7:0]  hiLen, loLen;
	logic [15:0] d;
	int          bad_count, compares, cyc, irqCnt, stCnt, gap, lastIrq, rises;
	int          seed, n, h, l, bi, bs, br;

	timer_channel dut_u (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .response(response), .timerInputPin(pin),
		.channelInterrupt(channelInterrupt), .startTrigger(startTrigger));
	pin_source src_u (.clk(clk), .run(run), .highLen(hiLen), .lowLen(loLen),
		.timerInputPin(pin));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Event bookkeeping
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (startTrigger === 1'b1)
			stCnt <= stCnt + 1;
		if (channelInterrupt === 1'b1) begin
			irqCnt <= irqCnt + 1;
			gap <= cyc - lastIrq;
			lastIrq <= cyc;
		end
	end
	always @(posedge pin) rises++;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] dat);
		int t;
		t = 0;
		address <= a;
		writedata <= dat;
		write <= wr;
		read <= ~wr;
		@(posedge clk);
		while (waitrequest !== 1'b0 && t < 50) begin
			@(posedge clk);
			t++;
		end
		if (waitrequest !== 1'b0)
			bad_count++;
		rdata = readdata;
		resp = response;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic waitIrq(input int cnt);
		int t;
		t = 0;
		while (irqCnt < cnt && t < 400) begin
			@(posedge clk);
			t++;
		end
		if (irqCnt < cnt)
			bad_count++;
	endtask

	function automatic logic [31:0] modeWord(chan_mode_e md, logic srcSel, logic filt);
		mode_reg_s m;
		m = '{filterOn: filt, opClockSel: 2'h0, countSourceSelect: srcSel, mode: md,
			startIrqSelect: 1'b1};
		return {24'h000000, m};
	endfunction

	function automatic int rnd(input int lo, input int span);
		return lo + ($unsigned($random(seed)) % span);
	endfunction

	task automatic stopChk;
		logic [31:0] c;
		acc(1'b1, `TC_ADDR_CTRL, 32'h00000002);
		acc(1'b0, `TC_ADDR_STATUS, 32'h0);
		check(rdata[0], 1'b0);
		acc(1'b0, `TC_ADDR_COUNT, 32'h0);
		c = rdata;
		repeat (9) @(posedge clk);
		acc(1'b0, `TC_ADDR_COUNT, 32'h0);
		check(rdata, c);
	endtask

	task automatic final_report;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(25 * 20000);
		bad_count++;
		final_report();
	end

	initial begin
		seed = 32'hfc64f01d;
		{cyc, irqCnt, stCnt, gap, lastIrq, rises, bad_count, compares} = '0;
		reset_n = 1'b0;
		{address, read, write, writedata, run} = '0;
		byteenable = 4'hF;
		hiLen = 8'h04;
		loLen = 8'h04;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		acc(1'b0, `TC_ADDR_STATUS, 32'h0);
		check(rdata, 32'h0);
		check(resp, 2'h0);
		acc(1'b0, 4'hF, 32'h0);
		check({resp, rdata}, {2'h2, 32'h0});
		// Interval timer: undivided, halved on select 0, quartered on select 2
		for (int k = 0; k < 3; k++) begin
			n = rnd(2, 8);
			acc(1'b1, `TC_ADDR_PRESC, (k == 2) ? 32'h0000_0200 : 32'(k));
			acc(1'b1, `TC_ADDR_DATA, 32'(n));
			acc(1'b1, `TC_ADDR_MODE,
				modeWord(MODE_INTERVAL, 1'b0, 1'b0) | ((k == 2) ? 32'h0000_0040 : 32'h0));
			bi = irqCnt;
			bs = stCnt;
			acc(1'b1, `TC_ADDR_CTRL, 32'h1);
			acc(1'b0, `TC_ADDR_STATUS, 32'h0);
			check(rdata[0], 1'b1);
			waitIrq(bi + 3);
			check(32'(stCnt - bs), 32'h1);
			check(32'(gap), 32'((n + 1) << k));
			acc(1'b0, `TC_ADDR_COUNT, 32'h0);
			check(rdata <= 32'(n), 1'b1);
			stopChk();
		end
		// Event counter on pin edges
		d = 16'($random(seed)) | 16'h0100;
		hiLen <= 8'(rnd(4, 8));
		loLen <= 8'(rnd(4, 8));
		acc(1'b1, `TC_ADDR_PRESC, 32'h0);
		acc(1'b1, `TC_ADDR_DATA, {16'h0, d});
		acc(1'b1, `TC_ADDR_MODE, modeWord(MODE_EVENT, 1'b1, 1'($random(seed))));
		acc(1'b1, `TC_ADDR_CTRL, 32'h1);
		acc(1'b0, `TC_ADDR_COUNT, 32'h0);
		check(rdata, {16'h0, d});
		br = rises;
		run <= 1'b1;
		repeat (80) @(posedge clk);
		run <= 1'b0;
		repeat (12) @(posedge clk);
		acc(1'b0, `TC_ADDR_COUNT, 32'h0);
		check(rdata, {16'h0, 16'(d - 16'(rises - br))});
		stopChk();
		// Capture of pulse interval
		h = rnd(3, 6);
		l = rnd(3, 6);
		hiLen <= 8'(h);
		loLen <= 8'(l);
		acc(1'b1, `TC_ADDR_MODE, modeWord(MODE_CAPTURE, 1'b0, 1'b0));
		bi = irqCnt;
		acc(1'b1, `TC_ADDR_CTRL, 32'h1);
		run <= 1'b1;
		waitIrq(bi + 4);
		acc(1'b0, `TC_ADDR_DATA, 32'h0);
		check(rdata, 32'(h + l - 1));
		run <= 1'b0;
		stopChk();
		// Single count armed by start, triggered by pin rise
		n = rnd(3, 16);
		acc(1'b1, `TC_ADDR_DATA, 32'(n));
		acc(1'b1, `TC_ADDR_MODE, modeWord(MODE_SINGLE, 1'b0, 1'b0));
		acc(1'b1, `TC_ADDR_CTRL, 32'h1);
		acc(1'b0, `TC_ADDR_STATUS, 32'h0);
		check(rdata[2:0], 3'h3);
		bi = irqCnt;
		repeat (10) @(posedge clk);
		check(32'(irqCnt - bi), 32'h0);
		hiLen <= 8'h3C;
		run <= 1'b1;
		waitIrq(bi + 1);
		acc(1'b0, `TC_ADDR_COUNT, 32'h0);
		check(rdata, 32'h0000FFFF);
		acc(1'b0, `TC_ADDR_STATUS, 32'h0);
		check(rdata[2:1], 2'h1);
		run <= 1'b0;
		stopChk();
		// Capture plus single count: high width
		h = rnd(6, 24);
		hiLen <= 8'(h);
		loLen <= 8'hC8;
		acc(1'b1, `TC_ADDR_MODE, modeWord(MODE_CAP_SINGLE, 1'b0, 1'b0));
		acc(1'b1, `TC_ADDR_CTRL, 32'h1);
		bi = irqCnt;
		run <= 1'b1;
		waitIrq(bi + 1);
		acc(1'b0, `TC_ADDR_DATA, 32'h0);
		check(rdata + 2 >= 32'(h) && rdata <= 32'(h + 1), 1'b1);
		run <= 1'b0;
		stopChk();
		final_report();
	end
endmodule

`default_nettype wire
